// >>> sim/exiop_field.sv
/*
 * Field side of the extended I/O block port: loads on output points,
 * switches on input points.
 * Assumes the enables come straight from the port block, one per point.
 */
`timescale 1ns/1ps
module exiop_field (
    input  wire logic [31:0] i_out,
    input  wire logic [31:0] i_oe,
    input  wire logic [31:0] i_sw,
    output logic [31:0]      o_pin
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // A driven pin shows the latch; an undriven one follows its switch,
    // so a block read of an input block sees the switch levels
    assign o_pin = (i_oe & i_out) | (~i_oe & i_sw);
endmodule

// >>> sim/exiop_port_tb.sv
/*
 * Self-checking bench for the extended I/O block port.
 * Assumes the package, design and field model are compiled first.
 */
`timescale 1ns/1ps
module exiop_port_tb;
    import exiop_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        i_clk = 1'b0, i_nrst = 1'b0, i_large = 1'b0;
    logic [15:0] i_gen_in = 16'h0000, o_gen_out;
    logic [31:0] i_ext_in, o_ext_out, o_ext_oe, sw = 32'h0000_0000;
    logic        o_ready, o_pt_err, o_blk_valid, o_blk_err, o_nv_we;
    logic        o_q_valid, o_q_level, o_q_err;
    logic [7:0]  o_blk_value, i_pw_m = 8'h00;
    logic [3:0]  o_nv_dir, i_dir = 4'h0, i_nv_dir = 4'h0;
    logic [47:0] o_nv_out, i_nv_out = 48'h0000_0000_0000;
    logic        i_dir_we = 1'b0, i_pt_valid = 1'b0, i_pw_valid = 1'b0;
    logic        i_pw_m_valid = 1'b0, i_pw_a_valid = 1'b0;
    logic        i_pw_b_valid = 1'b0, i_blk_valid = 1'b0;
    logic        i_q_valid = 1'b0, i_save = 1'b0, i_nv_valid = 1'b0;
    logic [15:0] i_pw_a = 16'h0000, i_pw_b = 16'h0000;
    logic [5:0]  i_pt_num = 6'h01, i_q_num = 6'h01;
    logic [31:0] i_pt_operand = 32'h0000_0000;
    logic [2:0]  i_blk_num = 3'h0;
    exiop_op_t   i_pt_op = EXIOP_OP_SET;
    int          err_count = 0, comparisons = 0;
    logic [31:0] eo;
    logic [15:0] go;

    always #5 i_clk = ~i_clk;

    exiop_port dut (.i_clk, .i_nrst, .i_large, .i_gen_in, .o_gen_out,
        .i_ext_in, .o_ext_out, .o_ext_oe, .o_ready, .i_dir_we, .i_dir,
        .i_pt_valid, .i_pt_op, .i_pt_num, .i_pt_operand, .o_pt_err,
        .i_pw_valid, .i_pw_m_valid, .i_pw_m, .i_pw_a_valid, .i_pw_a,
        .i_pw_b_valid, .i_pw_b, .i_blk_valid, .i_blk_num, .o_blk_valid,
        .o_blk_value, .o_blk_err, .i_q_valid, .i_q_num, .o_q_valid,
        .o_q_level, .o_q_err, .i_save, .o_nv_we, .o_nv_dir, .o_nv_out,
        .i_nv_valid, .i_nv_dir, .i_nv_out);

    exiop_field field (.i_out(o_ext_out), .i_oe(o_ext_oe), .i_sw(sw),
        .o_pin(i_ext_in));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] seen,
                       input logic [47:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Requests stand one cycle; outputs are looked at 1 ns after the edge
    task automatic step;
        @(posedge i_clk);
        {i_dir_we, i_pt_valid, i_pw_valid, i_blk_valid, i_q_valid,
         i_save} <= 6'h00;
        #1;
    endtask

    task automatic dirw(input logic [3:0] d);
        @(posedge i_clk);
        i_dir_we <= 1'b1;
        i_dir <= d;
        step;
    endtask

    task automatic pt(input exiop_op_t op, input logic [5:0] n,
                      input logic [31:0] v);
        @(posedge i_clk);
        i_pt_valid <= 1'b1;
        i_pt_op <= op;
        i_pt_num <= n;
        i_pt_operand <= v;
        step;
    endtask

    task automatic pw(input logic mv, input logic [7:0] m, input logic av,
                      input logic [15:0] a, input logic bv,
                      input logic [15:0] b);
        @(posedge i_clk);
        {i_pw_valid, i_pw_m_valid, i_pw_a_valid, i_pw_b_valid} <=
            {1'b1, mv, av, bv};
        {i_pw_m, i_pw_a, i_pw_b} <= {m, a, b};
        step;
    endtask

    task automatic rd(input logic [2:0] n, input logic [7:0] e,
                      input logic er);
        @(posedge i_clk);
        i_blk_valid <= 1'b1;
        i_blk_num <= n;
        step;
        chk("blk_valid", o_blk_valid, 48'h1);
        chk("blk_value", o_blk_value, e);
        chk("blk_err", o_blk_err, er);
    endtask

    task automatic qry(input logic [5:0] n, input logic e,
                       input logic er);
        @(posedge i_clk);
        i_q_valid <= 1'b1;
        i_q_num <= n;
        step;
        chk("q_valid", o_q_valid, 48'h1);
        chk("q_level", o_q_level, e);
        chk("q_err", o_q_err, er);
    endtask

    task automatic do_reset;
        @(posedge i_clk);
        i_nrst <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        for (int n = 0; n < 8 && o_ready !== 1'b1; n++) @(posedge i_clk);
        #1;
        chk("ready", o_ready, 48'h1);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_dir;
        logic [31:0] e;
        chk("oe_reset", o_ext_oe, 48'h0);
        chk("ext_reset", o_ext_out, 48'h0);
        for (int d = 0; d < 16; d++) begin
            dirw(d[3:0]);
            for (int k = 0; k < 4; k++) e[8*k +: 8] = {8{d[k]}};
            chk("ext_oe", o_ext_oe, e);
        end
        $display("done direction");
    endtask

    task automatic t_port;
        dirw(4'hC);
        pw(1'b1, 8'h07, 1'b0, 16'h0000, 1'b1, 16'h0007);
        go = 16'h0007;
        eo = 32'h0007_0000;
        chk("gen_out", o_gen_out, go);
        chk("ext_out", o_ext_out, eo);
        dirw(4'h4);
        pw(1'b0, 8'hFF, 1'b1, 16'hFFFF, 1'b1, 16'hFFFF);
        eo = 32'h00FF_0000;
        chk("ext_out", o_ext_out, eo);
        chk("gen_out", o_gen_out, go);
        dirw(4'h3);
        pw(1'b0, 8'h00, 1'b1, 16'hA55A, 1'b0, 16'h0000);
        chk("ext_out", o_ext_out, 48'h00FF_A55A);
        pw(1'b0, 8'h00, 1'b1, 16'h0000, 1'b0, 16'h0000);
        chk("ext_out", o_ext_out, eo);
        $display("done port write");
    endtask

    task automatic t_point;
        dirw(4'h1);
        pt(EXIOP_OP_SET, 6'h11, 32'h0000_0000);
        chk("ext_out", o_ext_out, 48'h00FF_0001);
        pt(EXIOP_OP_SET, 6'h19, 32'h0000_0000);
        chk("ext_out", o_ext_out, 48'h00FF_0001);
        pt(EXIOP_OP_CLR, 6'h11, 32'h0000_0000);
        chk("ext_out", o_ext_out, eo);
        pt(EXIOP_OP_COND, 6'h04, 32'h0000_0100);
        chk("gen_out", o_gen_out, 48'h000F);
        pt(EXIOP_OP_COND, 6'h04, 32'h0000_0000);
        chk("gen_out", o_gen_out, go);
        pt(EXIOP_OP_SET, 6'h09, 32'h0000_0000);
        chk("gen_out", o_gen_out, go);
        chk("pt_err", o_pt_err, 48'h1);
        @(posedge i_clk);
        i_large <= 1'b1;
        pt(EXIOP_OP_SET, 6'h09, 32'h0000_0000);
        go = 16'h0107;
        chk("gen_out", o_gen_out, go);
        chk("pt_err", o_pt_err, 48'h0);
        $display("done point write");
    endtask

    task automatic t_read;
        @(posedge i_clk);
        sw <= 32'hA5C3_5A3C;
        i_gen_in <= 16'h3396;
        dirw(4'h2);
        pw(1'b0, 8'h00, 1'b1, 16'h69FF, 1'b0, 16'h0000);
        eo = 32'h00FF_6900;
        chk("ext_out", o_ext_out, eo);
        rd(3'h0, 8'h96, 1'b0);
        rd(3'h2, 8'h3C, 1'b0);
        rd(3'h3, 8'h69, 1'b0);
        rd(3'h4, 8'hC3, 1'b0);
        rd(3'h1, 8'h00, 1'b1);
        qry(6'h11, 1'b0, 1'b0);
        qry(6'h13, 1'b1, 1'b0);
        qry(6'h03, 1'b1, 1'b0);
        qry(6'h19, 1'b1, 1'b0);
        qry(6'h30, 1'b1, 1'b0);
        qry(6'h00, 1'b0, 1'b1);
        $display("done reads");
    endtask

    task automatic t_save;
        @(posedge i_clk);
        i_save <= 1'b1;
        step;
        chk("nv_we", o_nv_we, 48'h1);
        chk("nv_dir", o_nv_dir, 48'h2);
        chk("nv_out", o_nv_out, {eo, go});
        @(posedge i_clk);
        i_nv_valid <= 1'b1;
        i_nv_dir <= 4'h2;
        i_nv_out <= {eo, go};
        do_reset;
        chk("oe_restore", o_ext_oe, 48'h0000_FF00);
        chk("ext_restore", o_ext_out, eo);
        chk("gen_restore", o_gen_out, go);
        $display("done save");
    endtask

    initial begin
        #200000;
        err_count++;
        wrap_up;
    end

    initial begin
        do_reset;
        t_dir;
        t_port;
        t_point;
        t_read;
        t_save;
        wrap_up;
    end
endmodule

// >>> verilog/exiop_pkg.sv
/*
 * Constants and types for the extended I/O block port.
 * Assumes one 100 MHz clock and a synchronous active-low reset.
 */
//
// Operation
// - 32 extended points, direction per eight-point group
// - Points 17-48 form blocks 2 to 5; block read here refuses block 5 and stops at block 4
// - Direction bit one makes block outputs
// - Direction bit 0 is block 2, bit 3 block 5
// - No saved setup: all blocks inputs
// - Save stores direction and output states
// - Set/clear points 1-8, 17-48, outputs only
// - Large variant accepts points 1 through 48
// - Conditional write: non-zero high, zero low
// - Port write first operand drives outputs 1-8
// - Further operands are 16-bit, points 17-48
// - Port bits on input points discarded
// - Omitted operand keeps group, supplied overwrites
// - Operand bit zero is lowest point
// - Block read of 0,2,3,4 returns eight bits
// - Point query covers 1-8 and 17-48
// - Point 17 is block 2 bit zero
package exiop_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          EXIOP_NPTS     = 48;
    localparam int          EXIOP_NBLK     = 4;
    localparam logic [3:0]  EXIOP_DIR_RST  = 4'h0;
    localparam logic [47:0] EXIOP_OUT_RST  = 48'h0000_0000_0000;
    localparam logic [7:0]  EXIOP_BYTE_RST = 8'h00;

    // ------------------------------------------------------------
    // Point and block numbers
    // ------------------------------------------------------------
    localparam logic [5:0]  EXIOP_PT_GEN_LO = 6'h01;
    localparam logic [5:0]  EXIOP_PT_GEN_HI = 6'h08;
    localparam logic [5:0]  EXIOP_PT_XTR_HI = 6'h10;
    localparam logic [5:0]  EXIOP_PT_EXT_LO = 6'h11;
    localparam logic [5:0]  EXIOP_PT_EXT_HI = 6'h30;
    localparam logic [2:0]  EXIOP_BLK_GEN   = 3'h0;
    localparam logic [2:0]  EXIOP_BLK_FIRST = 3'h2;
    localparam logic [2:0]  EXIOP_BLK_LAST  = 3'h4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EXIOP_OP_SET  = 2'b00,
        EXIOP_OP_CLR  = 2'b01,
        EXIOP_OP_COND = 2'b10
    } exiop_op_t;

    typedef enum logic [0:0] {
        EXIOP_ST_LOAD = 1'b0,
        EXIOP_ST_RUN  = 1'b1
    } exiop_state_t;

endpackage

// >>> verilog/exiop_point_dec.sv
/*
 * Point number decoder: checks a point number and gives its one-hot
 * position in the 48-bit point vector (bit n-1 for point n).
 * Assumes the number is stable while it is used; purely combinational.
 */
`timescale 1ns/1ps
module exiop_point_dec (
    input  wire logic [5:0]  i_num,
    input  wire logic        i_large,
    output logic             o_ok,
    output logic [47:0]      o_onehot
);
    import exiop_pkg::*;

    wire in_gen = (i_num >= EXIOP_PT_GEN_LO) && (i_num <= EXIOP_PT_GEN_HI);
    wire in_xtr = (i_num > EXIOP_PT_GEN_HI) && (i_num <= EXIOP_PT_XTR_HI);
    wire in_ext = (i_num >= EXIOP_PT_EXT_LO) && (i_num <= EXIOP_PT_EXT_HI);
    wire [5:0] idx = i_num - EXIOP_PT_GEN_LO;

    // Points 9-16 exist only on the large variant
    assign o_ok     = in_gen || in_ext || (in_xtr && i_large);
    assign o_onehot = o_ok ? (48'h0000_0000_0001 << idx)
                           : 48'h0000_0000_0000;
endmodule

// >>> verilog/exiop_port.sv
/*
 * Extended I/O block port: 16 general outputs, 32 extended points in four
 * switchable blocks, point and whole-port writes, block and point reads,
 * save and restore of the setup through an external nonvolatile store.
 * Assumes all inputs are synchronous to i_clk and that the store answers
 * i_nv_valid in the first cycle after reset release.
 */
`timescale 1ns/1ps
module exiop_port (
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_large,
    input  wire logic [15:0]          i_gen_in,
    output logic [15:0]               o_gen_out,
    input  wire logic [31:0]          i_ext_in,
    output logic [31:0]               o_ext_out,
    output logic [31:0]               o_ext_oe,
    output logic                      o_ready,
    input  wire logic                 i_dir_we,
    input  wire logic [3:0]           i_dir,
    input  wire logic                 i_pt_valid,
    input  wire exiop_pkg::exiop_op_t i_pt_op,
    input  wire logic [5:0]           i_pt_num,
    input  wire logic [31:0]          i_pt_operand,
    output logic                      o_pt_err,
    input  wire logic                 i_pw_valid,
    input  wire logic                 i_pw_m_valid,
    input  wire logic [7:0]           i_pw_m,
    input  wire logic                 i_pw_a_valid,
    input  wire logic [15:0]          i_pw_a,
    input  wire logic                 i_pw_b_valid,
    input  wire logic [15:0]          i_pw_b,
    input  wire logic                 i_blk_valid,
    input  wire logic [2:0]           i_blk_num,
    output logic                      o_blk_valid,
    output logic [7:0]                o_blk_value,
    output logic                      o_blk_err,
    input  wire logic                 i_q_valid,
    input  wire logic [5:0]           i_q_num,
    output logic                      o_q_valid,
    output logic                      o_q_level,
    output logic                      o_q_err,
    input  wire logic                 i_save,
    output logic                      o_nv_we,
    output logic [3:0]                o_nv_dir,
    output logic [47:0]               o_nv_out,
    input  wire logic                 i_nv_valid,
    input  wire logic [3:0]           i_nv_dir,
    input  wire logic [47:0]          i_nv_out
);
    import exiop_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    exiop_state_t  state_reg;
    logic [3:0]    dir_reg;
    logic [47:0]   out_reg;
    logic          pt_err_reg;
    logic          blk_valid_reg;
    logic [7:0]    blk_value_reg;
    logic          blk_err_reg;
    logic          q_valid_reg;
    logic          q_level_reg;
    logic          q_err_reg;
    logic          nv_we_reg;
    logic [3:0]    nv_dir_reg;
    logic [47:0]   nv_out_reg;

    // ------------------------------------------------------------
    // Direction masks
    // ------------------------------------------------------------
    logic [31:0]   ext_mask;
    genvar g;
    generate
        for (g = 0; g < EXIOP_NBLK; g++) begin : g_blk
            // One direction bit steers all eight points
            assign ext_mask[8*g +: 8] = {8{dir_reg[g]}};
        end
    endgenerate

    // Extra outputs 9-16 exist only on the large variant
    wire [7:0]  xtr_mask = i_large ? 8'hFF : 8'h00;
    wire [47:0] wr_mask  = {ext_mask, xtr_mask, 8'hFF};

    // Outputs read back their latch, inputs read their pins
    wire [31:0] ext_level = (out_reg[47:16] & ext_mask)
                          | (i_ext_in & ~ext_mask);
    wire [47:0] level     = {ext_level, i_gen_in};

    wire run = (state_reg == EXIOP_ST_RUN);

    // ------------------------------------------------------------
    // Whole-port write
    // ------------------------------------------------------------
    // Bit zero of each operand is the lowest point
    wire [47:0] pw_val = {i_pw_b, i_pw_a, 8'h00, i_pw_m};
    wire [47:0] pw_sel = {{16{i_pw_b_valid}}, {16{i_pw_a_valid}},
                          8'h00, {8{i_pw_m_valid}}};
    wire [47:0] pw_en  = pw_sel & wr_mask
                       & {48{i_pw_valid && run}};
    wire [47:0] after_pw = (out_reg & ~pw_en) | (pw_val & pw_en);

    // ------------------------------------------------------------
    // Single-point write
    // ------------------------------------------------------------
    logic          pt_ok;
    logic [47:0]   pt_hot;
    exiop_point_dec u_pt_dec (
        .i_num    (i_pt_num),
        .i_large  (i_large),
        .o_ok     (pt_ok),
        .o_onehot (pt_hot)
    );

    // Any set bit of the operand counts as high
    wire pt_bit = (i_pt_op == EXIOP_OP_SET)
               || ((i_pt_op == EXIOP_OP_COND) && (|i_pt_operand));
    // Input-configured points silently keep their pin
    wire [47:0] pt_en = pt_hot & wr_mask & {48{i_pt_valid && run}};
    // A point write lands after a same-cycle port write
    wire [47:0] out_next = (after_pw & ~pt_en) | ({48{pt_bit}} & pt_en);
    wire pt_err_next = i_pt_valid && run && !pt_ok;

    // ------------------------------------------------------------
    // Reads
    // ------------------------------------------------------------
    logic          q_ok;
    logic [47:0]   q_hot;
    exiop_point_dec u_q_dec (
        .i_num    (i_q_num),
        .i_large  (i_large),
        .o_ok     (q_ok),
        .o_onehot (q_hot)
    );

    wire q_level_next = |(level & q_hot);

    wire blk_ext = (i_blk_num >= EXIOP_BLK_FIRST)
                && (i_blk_num <= EXIOP_BLK_LAST);
    wire blk_ok  = blk_ext || (i_blk_num == EXIOP_BLK_GEN);
    wire [1:0] blk_sel = 2'(i_blk_num - EXIOP_BLK_FIRST);
    wire [7:0] blk_next = !blk_ok ? EXIOP_BYTE_RST
                        : blk_ext ? ext_level[8*blk_sel +: 8]
                        : i_gen_in[7:0];

    // ------------------------------------------------------------
    // Setup and restore
    // ------------------------------------------------------------
    // Without a saved image every block starts as input
    wire [3:0]  load_dir = i_nv_valid ? i_nv_dir : EXIOP_DIR_RST;
    wire [47:0] load_out = i_nv_valid ? i_nv_out : EXIOP_OUT_RST;
    wire [3:0]  dir_next = (i_dir_we && run) ? i_dir : dir_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_reg <= EXIOP_ST_LOAD;
            dir_reg   <= EXIOP_DIR_RST;
            out_reg   <= EXIOP_OUT_RST;
        end else begin
            case (state_reg)
                EXIOP_ST_LOAD: begin
                    state_reg <= EXIOP_ST_RUN;
                    dir_reg   <= load_dir;
                    out_reg   <= load_out;
                end
                default: begin
                    dir_reg   <= dir_next;
                    out_reg   <= out_next;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pt_err_reg    <= 1'b0;
            blk_valid_reg <= 1'b0;
            blk_value_reg <= EXIOP_BYTE_RST;
            blk_err_reg   <= 1'b0;
            q_valid_reg   <= 1'b0;
            q_level_reg   <= 1'b0;
            q_err_reg     <= 1'b0;
        end else begin
            pt_err_reg    <= pt_err_next;
            blk_valid_reg <= i_blk_valid && run;
            blk_value_reg <= blk_next;
            blk_err_reg   <= i_blk_valid && run && !blk_ok;
            q_valid_reg   <= i_q_valid && run;
            q_level_reg   <= q_level_next;
            q_err_reg     <= i_q_valid && run && !q_ok;
        end
    end

    // Snapshot taken before any same-cycle write lands
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            nv_we_reg  <= 1'b0;
            nv_dir_reg <= EXIOP_DIR_RST;
            nv_out_reg <= EXIOP_OUT_RST;
        end else begin
            nv_we_reg  <= i_save && run;
            if (i_save && run) begin
                nv_dir_reg <= dir_reg;
                nv_out_reg <= out_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_gen_out   = out_reg[15:0] & {xtr_mask, 8'hFF};
    assign o_ext_out   = out_reg[47:16];
    assign o_ext_oe    = ext_mask;
    assign o_ready     = run;
    assign o_pt_err    = pt_err_reg;
    assign o_blk_valid = blk_valid_reg;
    assign o_blk_value = blk_value_reg;
    assign o_blk_err   = blk_err_reg;
    assign o_q_valid   = q_valid_reg;
    assign o_q_level   = q_level_reg;
    assign o_q_err     = q_err_reg;
    assign o_nv_we     = nv_we_reg;
    assign o_nv_dir    = nv_dir_reg;
    assign o_nv_out    = nv_out_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_dir_default: assert property (
        (state_reg == EXIOP_ST_LOAD) && !i_nv_valid
        |=> (dir_reg == EXIOP_DIR_RST) && (o_ext_oe == 32'h0000_0000))
        else $error("direction not cleared without saved image");

    a_oe_block_grp: assert property (
        (o_ext_oe[7:0] == {8{dir_reg[0]}})
        && (o_ext_oe[31:24] == {8{dir_reg[3]}}))
        else $error("pin enables do not follow block direction");

    a_input_kept: assert property (
        run && $past(run)
        |-> ((out_reg ^ $past(out_reg)) & ~$past(wr_mask))
            == 48'h0000_0000_0000)
        else $error("latch changed on an input point");

    a_port_gen_write: assert property (
        run && i_pw_valid && i_pw_m_valid && !i_pt_valid
        |=> o_gen_out[7:0] == $past(i_pw_m))
        else $error("general outputs not set by port write");

    a_port_ext_write: assert property (
        run && i_pw_valid && i_pw_a_valid && !i_pt_valid
        && (dir_reg[1:0] == 2'b11)
        |=> o_ext_out[15:0] == $past(i_pw_a))
        else $error("extended group a not written");

    a_port_omitted: assert property (
        run && i_pw_valid && !i_pw_b_valid && !i_pt_valid && !i_dir_we
        |=> $stable(o_ext_out[31:16]))
        else $error("omitted operand changed its group");

    a_cond_point: assert property (
        run && i_pt_valid && (i_pt_op == EXIOP_OP_COND) && (|pt_en)
        |=> (|(out_reg & $past(pt_en))) == $past(|i_pt_operand))
        else $error("conditional write gave wrong level");

    a_clear_point: assert property (
        run && i_pt_valid && (i_pt_op == EXIOP_OP_CLR) && (|pt_en)
        |=> !(|(out_reg & $past(pt_en))))
        else $error("clear did not clear the point");

    a_save_snap: assert property (
        run && i_save
        |=> o_nv_we && (o_nv_dir == $past(dir_reg))
            && (o_nv_out == $past(out_reg)) ##1 !o_nv_we || $past(i_save))
        else $error("save snapshot wrong");

    a_query_seventeen: assert property (
        run && i_q_valid && (i_q_num == EXIOP_PT_EXT_LO) && !dir_reg[0]
        |=> o_q_valid && (o_q_level == $past(i_ext_in[0])))
        else $error("point 17 query not block 2 bit zero");

    a_block_read: assert property (
        run && i_blk_valid && (i_blk_num == EXIOP_BLK_FIRST)
        && !dir_reg[0]
        |=> o_blk_valid && !o_blk_err
            && (o_blk_value == $past(i_ext_in[7:0])))
        else $error("block 2 read wrong");

    a_point_refused: assert property (
        run && i_pt_valid && !i_large
        && (i_pt_num > EXIOP_PT_GEN_HI) && (i_pt_num < EXIOP_PT_EXT_LO)
        |=> o_pt_err)
        else $error("extra point accepted on small variant");

    a_block_refused: assert property (
        run && i_blk_valid && (i_blk_num > EXIOP_BLK_GEN)
        && (i_blk_num < EXIOP_BLK_FIRST)
        |=> o_blk_valid && o_blk_err && (o_blk_value == EXIOP_BYTE_RST))
        else $error("block one read not refused");

endmodule
